// ===== shared/bkoc_pkg.sv
// Constants, register map and state types of the buck protection and phase control block
package bkoc_pkg;

  // Clock and timing
  localparam int unsigned CLK_MHZ      = 50;
  localparam int unsigned DEAD_TIME_NS = 40;
  localparam logic [3:0]  DEAD_CYC     = 4'((DEAD_TIME_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0]  OSC_LAST     = 4'h7;   // Internal oscillator wraps every 8 clocks
  localparam logic [3:0]  OSC_HALF     = 4'h4;   // Half period marks the 180 degree point
  localparam logic [4:0]  SYNC_GAP     = 5'h10;  // Missing sync edges for this long drops lock
  localparam logic [1:0]  LOCK_EDGES   = 2'h2;   // Sync edges seen before locking on

  // Overcurrent and hiccup counts
  localparam logic [9:0]  OVL_LAST     = 10'h1FF; // 512th limited cycle
  localparam logic [1:0]  CLEAN_LAST   = 2'h3;    // 4th clean cycle in a row
  localparam logic [4:0]  CLAMP_EVENTS = 5'h10;   // 16 events arm the clamp
  localparam int unsigned HICCUP_OFF   = 16384;

  // Decoded strap codes from the strap window comparator
  localparam logic [2:0]  STRAP_P_SINGLE   = 3'h0;
  localparam logic [2:0]  STRAP_P_SPREAD   = 3'h1;
  localparam logic [2:0]  STRAP_P_DUAL     = 3'h2;
  localparam logic [2:0]  STRAP_P_DUAL_SPR = 3'h3;
  localparam logic [2:0]  STRAP_SECONDARY  = 3'h4;

  // Register byte offsets
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_DEAD   = 4'h4;
  localparam logic [3:0]  REG_STATUS = 4'h8;
  localparam logic [3:0]  REG_COUNT  = 4'hC;

  // Field positions and reset values
  localparam int unsigned CTRL_DRIVE_BIT = 0;
  localparam int unsigned CTRL_SYNC_BIT  = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h3;
  localparam int unsigned COUNT_OFF_LSB  = 16;

  // Gate drive sequencer states
  typedef enum logic [2:0] {
    GATE_OFF,
    GATE_HS,
    GATE_HS_FALL,
    GATE_DEAD,
    GATE_LS,
    GATE_LS_FALL
  } bkoc_gate_t;

endpackage : bkoc_pkg

// ===== rtl/bkoc_ctrl.sv
// Buck controller protection, gate sequencing, strap decode and phase sync logic
// Operation
// [RULE_01] Sense above 60 mV ends the high-side pulse at once within the cycle.
// [RULE_02] During overcurrent the soft-start level is clamped 150 mV above feedback.
// [RULE_03] Clamp engages only after sixteen overcurrent events are counted.
// [RULE_04] Overload gives 512 cycles of cycle-by-cycle limiting before hiccup.
// [RULE_05] Four consecutive clean cycles return the 512-cycle counter to zero.
// [RULE_06] Expiry pulls soft start low, stops both drives, starts off-time count.
// [RULE_07] Off-time count reaching 16384 releases soft start and restarts output.
// [RULE_08] Hiccup is inhibited during soft start until feedback passes 0.4 V.
// [RULE_09] Low side turns on only after high side falls below 2 V plus delay.
// [RULE_10] High side turns on only after low side falls below 2 V.
// [RULE_11] Strap latched when bias passes 3.3 V; changes need a power cycle.
// [RULE_12] Five strap values select primary, spreading, dual phase or secondary.
// [RULE_13] Primary with spreading never locks to an external clock.
// [RULE_14] Secondary disables its error amplifier, leaving its output floating.
// [RULE_15] Dual phase forbids internal compensation; external only.
// [RULE_16] Dual-phase primary drives a 180 degree shifted clock on power-good pin.
// [RULE_17] Secondary switches on primary clock; frequency resistor only sets slope.
// [RULE_18] System enables both controllers together; secondary enable may shed phase.
// [RULE_19] Pulse skip or forced PWM needs both mode pins tied alike.
// [RULE_20] External clock on primary requires secondary strapped for forced PWM.
// [RULE_21] External sync appearing after start-up locks after two clock cycles.
// [RULE_22] Pulse skipping primary stops its sync clock output.
// [RULE_23] Re-enabled secondary pulls soft start low and soft-starts normally.
// [RULE_24] Counters step once per switching cycle and clear at power-on.
`timescale 1ns/1ps
`default_nettype none

module bkoc_ctrl #(
  parameter int unsigned HICCUP_OFF_CYCLES = bkoc_pkg::HICCUP_OFF
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // Analog comparator results, asynchronous to clock_i
  input  wire logic        over_limit_i,          // Sense above 60 mV
  input  wire logic        pwm_reset_i,           // PWM comparator ends on time
  input  wire logic        fb_above_i,            // Feedback above 0.4 V
  input  wire logic        hs_below_i,            // High-side gate below 2 V
  input  wire logic        ls_below_i,            // Low-side gate below 2 V
  input  wire logic        bias_ok_i,             // Bias above 3.3 V
  input  wire logic [2:0]  config_strap_i,        // Decoded strap code
  input  wire logic        enable_i,              // Enable pin above threshold
  input  wire logic        light_load_sync_pin_i, // Mode level or sync clock
  input  wire logic        skipping_i,            // Pulses being skipped
  input  wire logic        power_good_i,          // Output in regulation
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Drives and controls
  output logic             high_side_drive_o,
  output logic             low_side_drive_o,
  output logic             soft_start_pull_low_o,
  output logic             ss_clamp_en_o,
  output logic             error_amp_enable_o,
  output logic             internal_comp_allow_o,
  output logic             spread_modulation_o,
  output logic             power_good_sync_o,
  output logic             power_good_sync_oe_o
);
  import bkoc_pkg::*;

  // Two-flop synchronisers for every asynchronous input
  localparam int unsigned NSYNC = 13;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  assign async_in = {config_strap_i, over_limit_i, pwm_reset_i, fb_above_i, hs_below_i,
                     ls_below_i, bias_ok_i, enable_i, light_load_sync_pin_i, skipping_i,
                     power_good_i};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= async_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  logic [2:0] strap_s;
  logic oc_s, pwmr_s, fb_s, hsb_s, lsb_s, bias_s, en_s, pin_s, skip_s, pg_s;
  assign {strap_s, oc_s, pwmr_s, fb_s, hsb_s, lsb_s, bias_s, en_s, pin_s, skip_s, pg_s} =
         sync_q;

  // Registers
  logic [1:0]  ctrl;
  logic [3:0]  dead_cfg;
  logic        cfg_done, cfg_secondary, cfg_spread, cfg_dual;
  logic        hiccup, ss_active, ext_locked, oc_seen, pin_q;
  logic [9:0]  ovl_cnt;
  logic [1:0]  clean_cnt;
  logic [4:0]  oc_events;
  logic [14:0] off_cnt;
  logic [3:0]  osc_cnt, phase_cnt, dead_cnt;
  logic [1:0]  lock_edges;
  logic [4:0]  gap_cnt;
  bkoc_gate_t  gate_st, next_gate;

  // Strap latch once bias is good; cleared only by reset or by losing bias
  always_ff @(posedge clock_i) begin
    if (rst_i || !bias_s) begin
      cfg_done      <= 1'b0;
      cfg_secondary <= 1'b0;
      cfg_spread    <= 1'b0;
      cfg_dual      <= 1'b0;
    end else if (!cfg_done) begin // [RULE_11]
      cfg_done      <= 1'b1;
      cfg_secondary <= (strap_s == STRAP_SECONDARY); // [RULE_12]
      cfg_spread    <= (strap_s == STRAP_P_SPREAD) || (strap_s == STRAP_P_DUAL_SPR);
      cfg_dual      <= (strap_s == STRAP_P_DUAL) || (strap_s == STRAP_P_DUAL_SPR)
                       || (strap_s == STRAP_SECONDARY);
    end
  end

  // Switching cycle source: own oscillator, external sync or the primary's clock
  logic pin_rise, osc_tick, cyc_start, sync_usable, run;
  assign pin_rise    = pin_s && !pin_q;
  assign osc_tick    = (osc_cnt == OSC_LAST);
  // Unlatched strap must not allow a lock that a spreading strap would then inherit
  assign sync_usable = cfg_done && !cfg_secondary && !cfg_spread && ctrl[CTRL_SYNC_BIT]; // [RULE_13]
  assign cyc_start   = (cfg_secondary || ext_locked) ? pin_rise : osc_tick; // [RULE_17]

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pin_q   <= 1'b0;
      osc_cnt <= 4'h0;
    end else begin
      pin_q   <= pin_s;
      osc_cnt <= osc_tick ? 4'h0 : osc_cnt + 4'h1;
    end
  end

  // Lock after two sync edges; a long gap falls back to the oscillator
  always_ff @(posedge clock_i) begin
    if (rst_i || !sync_usable) begin
      ext_locked <= 1'b0;
      lock_edges <= 2'h0;
      gap_cnt    <= 5'h0;
    end else if (pin_rise) begin
      gap_cnt <= 5'h0;
      if (lock_edges == LOCK_EDGES - 2'h1) begin
        ext_locked <= 1'b1; // [RULE_21]
      end else begin
        lock_edges <= lock_edges + 2'h1;
      end
    end else if (gap_cnt == SYNC_GAP) begin
      ext_locked <= 1'b0;
      lock_edges <= 2'h0;
    end else begin
      gap_cnt <= gap_cnt + 5'h1;
    end
  end

  // Overcurrent seen anywhere in the current cycle; a new event beats the clear
  logic oc_now, inhibit;
  assign oc_now  = oc_seen || oc_s;
  assign inhibit = ss_active && !fb_s;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      oc_seen <= 1'b0;
    end else begin
      oc_seen <= oc_s || (oc_seen && !cyc_start);
    end
  end

  // Overload counter with clean-cycle reset, clamp event counter
  always_ff @(posedge clock_i) begin
    if (rst_i || hiccup) begin // [RULE_24]
      ovl_cnt   <= 10'h0;
      clean_cnt <= 2'h0;
      oc_events <= 5'h0;
    end else if (cyc_start) begin
      if (oc_now) begin
        clean_cnt <= 2'h0;
        if (ovl_cnt != OVL_LAST) begin
          ovl_cnt <= ovl_cnt + 10'h1; // [RULE_04]
        end else if (!inhibit) begin
          ovl_cnt <= 10'h0;
        end
        if (oc_events != CLAMP_EVENTS) begin
          oc_events <= oc_events + 5'h1; // [RULE_03]
        end
      end else if (clean_cnt == CLEAN_LAST) begin
        ovl_cnt   <= 10'h0; // [RULE_05]
        oc_events <= 5'h0;
      end else begin
        clean_cnt <= clean_cnt + 2'h1;
      end
    end
  end

  // Hiccup entry and off-time count; held off during soft start while feedback is below 0.4 V
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hiccup  <= 1'b0;
      off_cnt <= 15'h0;
    end else if (!hiccup) begin
      off_cnt <= 15'h0;
      hiccup  <= cyc_start && oc_now && (ovl_cnt == OVL_LAST) && !inhibit; // [RULE_06] [RULE_08]
    end else if (cyc_start) begin
      if (off_cnt == 15'(HICCUP_OFF_CYCLES - 1)) begin
        hiccup  <= 1'b0; // [RULE_07]
        off_cnt <= 15'h0;
      end else begin
        off_cnt <= off_cnt + 15'h1;
      end
    end
  end

  // Soft start tracking: any pull-low restarts it, feedback above 0.4 V ends it
  always_ff @(posedge clock_i) begin
    if (rst_i || soft_start_pull_low_o) begin
      ss_active <= 1'b1;
    end else if (fb_s) begin
      ss_active <= 1'b0;
    end
  end

  // Soft start pull-low, clamp and amplifier controls
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      soft_start_pull_low_o <= 1'b1;
      ss_clamp_en_o         <= 1'b0;
      error_amp_enable_o    <= 1'b0;
      internal_comp_allow_o <= 1'b0;
      spread_modulation_o   <= 1'b0;
    end else begin
      soft_start_pull_low_o <= hiccup || !en_s || !cfg_done; // [RULE_06] [RULE_23]
      ss_clamp_en_o         <= (oc_events == CLAMP_EVENTS) && !hiccup; // [RULE_02]
      error_amp_enable_o    <= cfg_done && !cfg_secondary; // [RULE_14]
      internal_comp_allow_o <= cfg_done && !cfg_dual; // [RULE_15]
      spread_modulation_o   <= cfg_spread && !ext_locked;
    end
  end

  // Gate sequencer: each side waits for the other gate to read below 2 V
  assign run = cfg_done && en_s && ctrl[CTRL_DRIVE_BIT] && !hiccup && !soft_start_pull_low_o;
  always_comb begin
    next_gate = gate_st;
    case (gate_st)
      GATE_OFF:     if (run && cyc_start) next_gate = GATE_LS_FALL;
      GATE_LS_FALL: if (!run) next_gate = GATE_OFF;
                    else if (lsb_s) next_gate = GATE_HS; // [RULE_10]
      GATE_HS:      if (!run || oc_s || pwmr_s) next_gate = GATE_HS_FALL; // [RULE_01]
      GATE_HS_FALL: if (hsb_s) next_gate = GATE_DEAD;
      GATE_DEAD:    if (!hsb_s) next_gate = GATE_HS_FALL;
                    else if (!run) next_gate = GATE_OFF;
                    else if (dead_cnt >= dead_cfg) next_gate = GATE_LS; // [RULE_09]
      GATE_LS:      if (!run) next_gate = GATE_OFF;
                    else if (cyc_start) next_gate = GATE_LS_FALL;
      default:      next_gate = GATE_OFF;
    endcase
  end

  // State, dead-time counter and registered drives
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      gate_st           <= GATE_OFF;
      dead_cnt          <= 4'h0;
      high_side_drive_o <= 1'b0;
      low_side_drive_o  <= 1'b0;
    end else begin
      gate_st           <= next_gate;
      dead_cnt          <= (gate_st == GATE_DEAD) ? dead_cnt + 4'h1 : 4'h0;
      high_side_drive_o <= (next_gate == GATE_HS);
      low_side_drive_o  <= (next_gate == GATE_LS);
    end
  end

  // Power-good pin: shifted clock for a dual-phase primary, else open-drain status
  logic clk_mode;
  assign clk_mode = cfg_done && cfg_dual && !cfg_secondary && !skip_s; // [RULE_16] [RULE_22]
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      phase_cnt            <= 4'h0;
      power_good_sync_o    <= 1'b0;
      power_good_sync_oe_o <= 1'b0;
    end else begin
      phase_cnt <= cyc_start ? 4'h0 : ((phase_cnt == 4'hF) ? phase_cnt : phase_cnt + 4'h1);
      power_good_sync_o    <= clk_mode && (phase_cnt >= OSC_HALF);
      power_good_sync_oe_o <= clk_mode || !pg_s || !cfg_done;
    end
  end

  // Avalon slave: one wait state, answer on the edge waitrequest is low
  logic req;
  assign req = avs_read_i || avs_write_i;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
    end else begin
      avs_waitrequest_o <= !(req && avs_waitrequest_o);
      if (avs_read_i && avs_waitrequest_o) begin
        case (avs_address_i)
          REG_CTRL:   avs_readdata_o <= {30'h0, ctrl};
          REG_DEAD:   avs_readdata_o <= {28'h0, dead_cfg};
          REG_STATUS: avs_readdata_o <= {24'h0, ss_active, ext_locked, ss_clamp_en_o, hiccup,
                                         cfg_dual, cfg_spread, cfg_secondary, cfg_done};
          REG_COUNT:  avs_readdata_o <= {1'b0, off_cnt, 6'h0, ovl_cnt};
          default:    avs_readdata_o <= 32'h0;
        endcase
      end
    end
  end

  // Register writes take effect on the completing edge
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl     <= CTRL_RESET;
      dead_cfg <= DEAD_CYC;
    end else if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]) begin
      if (avs_address_i == REG_CTRL) begin
        ctrl <= avs_writedata_i[1:0];
      end
      if (avs_address_i == REG_DEAD) begin
        dead_cfg <= avs_writedata_i[3:0];
      end
    end
  end

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_NO_OVERLAP: assert property (!(high_side_drive_o && low_side_drive_o)) // [RULE_09]
    else $error("both gate drives on");
  AST_OC_ENDS_HS: assert property ((gate_st == GATE_HS) && oc_s |=> !high_side_drive_o) // [RULE_01]
    else $error("high side not ended by overcurrent");
  AST_LS_AFTER_HS: assert property ($rose(low_side_drive_o) |-> $past(hsb_s) && !$past(high_side_drive_o)) // [RULE_09]
    else $error("low side rose before high side fell");
  AST_HS_AFTER_LS: assert property ($rose(high_side_drive_o) |-> $past(lsb_s) && !$past(low_side_drive_o)) // [RULE_10]
    else $error("high side rose before low side fell");
  AST_CLAMP_COUNT: assert property ($rose(ss_clamp_en_o) |-> $past(oc_events) == CLAMP_EVENTS) // [RULE_03]
    else $error("clamp before sixteen events");
  AST_HICCUP_ENTRY: assert property ($rose(hiccup) |-> $past(ovl_cnt) == OVL_LAST && !$past(inhibit)) // [RULE_04]
    else $error("hiccup without 512 limited cycles");
  AST_HICCUP_OFF: assert property (hiccup |=> !high_side_drive_o && !low_side_drive_o ##0 soft_start_pull_low_o) // [RULE_06]
    else $error("drives or soft start active in hiccup");
  AST_HICCUP_END: assert property ($fell(hiccup) |-> $past(off_cnt) == 15'(HICCUP_OFF_CYCLES - 1)) // [RULE_07]
    else $error("hiccup ended at wrong count");
  AST_CLEAN_RESET: assert property (cyc_start && !oc_now && clean_cnt == CLEAN_LAST |=> ovl_cnt == 10'h0) // [RULE_05]
    else $error("clean cycles did not reset counter");
  AST_STRAP_HELD: assert property (cfg_done && $past(cfg_done) |-> $stable({cfg_secondary, cfg_spread, cfg_dual})) // [RULE_11]
    else $error("strap changed while latched");
  AST_SPREAD_NO_SYNC: assert property (cfg_spread |-> !ext_locked) // [RULE_13]
    else $error("spreading primary locked to external clock");
  AST_SECONDARY_AMP: assert property (cfg_secondary |=> !error_amp_enable_o) // [RULE_14]
    else $error("secondary amplifier enabled");

  COV_HICCUP: cover property ($rose(hiccup));
  COV_LOCK: cover property ($rose(ext_locked));
  COV_CLAMP: cover property ($rose(ss_clamp_en_o));
  COV_LS_ON: cover property ($rose(low_side_drive_o));

endmodule : bkoc_ctrl

`default_nettype wire

// ===== sim/bkoc_stage_model.sv
// Power stage and sync source model on the far side of the gate drive pins
`timescale 1ns/1ps
`default_nettype none
module bkoc_stage_model (
  input  wire logic clock_i,
  input  wire logic high_side_drive_i,
  input  wire logic low_side_drive_i,
  input  wire logic sync_run_i,
  output logic      hs_below_o,
  output logic      ls_below_o,
  output logic      pwm_reset_o,
  output logic      sync_o
);
  logic [3:0] hs_q = 4'h0;
  logic [1:0] ls_q = 2'h0;
  logic       osc  = 1'b0;
  // Gates lag their command by two clocks, so a hasty sequencer would overlap them
  always @(posedge clock_i) begin
    hs_q <= {hs_q[2:0], high_side_drive_i};
    ls_q <= {ls_q[0], low_side_drive_i};
  end
  assign hs_below_o  = ~hs_q[1];
  assign ls_below_o  = ~ls_q[1];
  assign pwm_reset_o = hs_q[3]; // On time ends four clocks after turn-on
  // Free running link clock, unrelated in phase to clock_i
  initial begin
    #13;
    forever #80 osc = ~osc;
  end
  // Pin rests low between bursts, the forced PWM level
  assign sync_o = sync_run_i & osc;
endmodule : bkoc_stage_model
`default_nettype wire

// ===== sim/bkoc_ctrl_test.sv
// Self-checking bench for the buck protection and phase control block
`timescale 1ns/1ps
`default_nettype none
module bkoc_ctrl_test;
  import bkoc_pkg::*;
  typedef struct packed {
    logic [2:0] strap;
    logic [3:0] status;
    logic [2:0] outs;
  } bkoc_row_t;
  logic        clock_i = 1'b0, rst_i = 1'b1, over_limit_i = 1'b0, fb_above_i = 1'b1;
  logic        bias_ok_i = 1'b0, enable_i = 1'b1, skipping_i = 1'b0, sync_run = 1'b0;
  logic [2:0]  config_strap_i = 3'h0;
  logic [3:0]  avs_address_i = 4'h0, avs_byteenable_i = 4'h0;
  logic        avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic        avs_waitrequest_o, high_side_drive_o, low_side_drive_o, soft_start_pull_low_o;
  logic        ss_clamp_en_o, error_amp_enable_o, internal_comp_allow_o, spread_modulation_o;
  logic        power_good_sync_o, power_good_sync_oe_o, hs_below, ls_below, pwm_rst, sync_pin;
  logic [3:0]  hb = 4'h0, lb = 4'h0;
  logic        hs_p = 1'b0, ls_p = 1'b0;
  int          miscompares = 0, checks_done = 0, t, r;
  bkoc_row_t   rows [5] = '{{3'h0, 4'h1, 3'h6}, {3'h1, 4'h5, 3'h7}, {3'h2, 4'h9, 3'h4},
                            {3'h3, 4'hD, 3'h5}, {3'h4, 4'hB, 3'h0}};
  logic [3:0]  ra [4] = '{REG_CTRL, REG_DEAD, 4'h1, REG_COUNT};
  logic [31:0] rv [4] = '{32'h3, 32'h2, 32'h0, 32'h0};
  logic [4:0]  lk [3] = '{{STRAP_P_SINGLE, 2'h3}, {STRAP_P_SPREAD, 2'h2},
                          {STRAP_P_SINGLE, 2'h0}}; // Strap, sync allowed bit, lock expected

  bkoc_ctrl #(.HICCUP_OFF_CYCLES(20)) DUT (.clock_i(clock_i), .rst_i(rst_i),
    .over_limit_i(over_limit_i), .pwm_reset_i(pwm_rst), .fb_above_i(fb_above_i),
    .hs_below_i(hs_below), .ls_below_i(ls_below), .bias_ok_i(bias_ok_i),
    .config_strap_i(config_strap_i), .enable_i(enable_i), .light_load_sync_pin_i(sync_pin),
    .skipping_i(skipping_i), .power_good_i(1'b1), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .high_side_drive_o(high_side_drive_o),
    .low_side_drive_o(low_side_drive_o), .soft_start_pull_low_o(soft_start_pull_low_o),
    .ss_clamp_en_o(ss_clamp_en_o), .error_amp_enable_o(error_amp_enable_o),
    .internal_comp_allow_o(internal_comp_allow_o), .spread_modulation_o(spread_modulation_o),
    .power_good_sync_o(power_good_sync_o), .power_good_sync_oe_o(power_good_sync_oe_o));
  bkoc_stage_model stage (.clock_i(clock_i), .high_side_drive_i(high_side_drive_o),
    .low_side_drive_i(low_side_drive_o), .sync_run_i(sync_run), .hs_below_o(hs_below),
    .ls_below_o(ls_below), .pwm_reset_o(pwm_rst), .sync_o(sync_pin));

  // 50 MHz system clock
  initial begin
    forever #10 clock_i = ~clock_i;
  end
  // Gate watch: no overlap, and each turn-on only after the other gate fell
  always @(posedge clock_i) begin
    hb <= {hb[2:0], hs_below};
    lb <= {lb[2:0], ls_below};
    hs_p <= high_side_drive_o;
    ls_p <= low_side_drive_o;
    if ((high_side_drive_o & low_side_drive_o) | (high_side_drive_o & ~hs_p & ~lb[2]) |
        (low_side_drive_o & ~ls_p & ~hb[3])) begin
      miscompares++;
      $display("Error %0t: gate overlap or early turn-on", $time);
    end
  end
  function automatic logic sig(input int s);
    case (s)
      0: return ss_clamp_en_o;
      1: return soft_start_pull_low_o;
      2: return ~soft_start_pull_low_o;
      3: return high_side_drive_o;
      4: return power_good_sync_o;
      default: return high_side_drive_o | low_side_drive_o;
    endcase
  endfunction : sig
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One Avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge clock_i);
    avs_address_i <= a;
    avs_read_i <= ~w;
    avs_write_i <= w;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (avs_waitrequest_o !== 1'b0) begin
      miscompares++;
      $display("Error %0t: bus request never answered", $time);
    end
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  // Bias dip and return, which relatches the strap
  task automatic pwr(input logic [2:0] s);
    @(posedge clock_i);
    bias_ok_i <= 1'b0;
    config_strap_i <= s;
    repeat (8) @(posedge clock_i);
    bias_ok_i <= 1'b1;
    repeat (12) @(posedge clock_i);
  endtask : pwr
  task automatic wt(input int s, input int n);
    t = 0;
    while (sig(s) !== 1'b1 && t < n) begin
      @(posedge clock_i);
      t++;
    end
    #1;
  endtask : wt
  task automatic cnt(input int s, input int n);
    logic p;
    r = 0;
    p = sig(s);
    repeat (n) begin
      @(posedge clock_i);
      #1;
      if (sig(s) === 1'b1 && p !== 1'b1) r++;
      p = sig(s);
    end
  endtask : cnt
  task automatic conclude();
    $display("Checks %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  // Watchdog sized well above the expected run of about 10000 clocks
  initial begin
    #1000000;
    miscompares++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    chk({avs_waitrequest_o, high_side_drive_o, low_side_drive_o, soft_start_pull_low_o}, 4'h9);
    pwr(3'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, ra[i], 32'h0, 4'hF);
      chk(q, rv[i]); // Reset values; unmapped address reads zero
    end
    bus(1'b1, REG_DEAD, 32'h5, 4'h0);
    bus(1'b0, REG_DEAD, 32'h0, 4'hF);
    chk(q, 32'h2); // Write without byte lane 0 is dropped
    $display("registers done");
    foreach (rows[i]) begin
      pwr(rows[i].strap);
      bus(1'b0, REG_STATUS, 32'h0, 4'hF);
      chk(q[3:0], rows[i].status);
      chk({error_amp_enable_o, internal_comp_allow_o, spread_modulation_o}, rows[i].outs);
    end
    config_strap_i <= 3'h0;
    repeat (10) @(posedge clock_i);
    bus(1'b0, REG_STATUS, 32'h0, 4'hF);
    chk(q[3:0], 4'hB);
    $display("strap done");
    pwr(3'h0);
    wt(3, 40);
    chk(t < 40, 1'b1);
    over_limit_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    chk(high_side_drive_o, 1'b0);
    repeat (80) @(posedge clock_i);
    #1;
    chk(ss_clamp_en_o, 1'b0);
    wt(0, 200);
    chk(ss_clamp_en_o, 1'b1);
    bus(1'b0, REG_COUNT, 32'h0, 4'hF);
    chk(q[9:0] >= 10'h00F && q[9:0] <= 10'h011, 1'b1);
    over_limit_i <= 1'b0;
    repeat (14) @(posedge clock_i);
    bus(1'b0, REG_COUNT, 32'h0, 4'hF);
    chk(q[9:0] != 10'h000, 1'b1);
    repeat (40) @(posedge clock_i);
    bus(1'b0, REG_COUNT, 32'h0, 4'hF);
    chk({q[9:0], ss_clamp_en_o}, 11'h000);
    $display("limit done");
    over_limit_i <= 1'b1;
    wt(1, 4400);
    chk(t >= 4070 && t <= 4110, 1'b1);
    over_limit_i <= 1'b0;
    cnt(6, 136);
    chk(r, 0);
    wt(2, 60);
    chk(t <= 40, 1'b1);
    fb_above_i <= 1'b0;
    pwr(3'h0);
    over_limit_i <= 1'b1;
    repeat (4500) @(posedge clock_i);
    bus(1'b0, REG_COUNT, 32'h0, 4'hF);
    chk(q[9:0], OVL_LAST);
    bus(1'b0, REG_STATUS, 32'h0, 4'hF);
    chk(q[4], 1'b0);
    over_limit_i <= 1'b0;
    fb_above_i <= 1'b1;
    bus(1'b1, REG_CTRL, 32'h2, 4'h1);
    cnt(6, 40);
    chk(r, 0); // Drive enable bit off keeps both gates quiet
    bus(1'b1, REG_CTRL, 32'h3, 4'h1);
    $display("hiccup done");
    pwr(3'h2);
    cnt(4, 80);
    chk(r >= 9 && r <= 11, 1'b1);
    chk(power_good_sync_oe_o, 1'b1);
    skipping_i <= 1'b1;
    repeat (3) @(posedge clock_i); // Let the skip level through the synchroniser
    cnt(4, 80);
    chk(r, 0);
    chk(power_good_sync_oe_o, 1'b0);
    skipping_i <= 1'b0;
    $display("sync out done");
    foreach (lk[i]) begin
      pwr(lk[i][4:2]);
      bus(1'b1, REG_CTRL, {30'h0, lk[i][1], 1'b1}, 4'h1);
      sync_run <= 1'b1;
      repeat (80) @(posedge clock_i);
      bus(1'b0, REG_STATUS, 32'h0, 4'hF);
      chk(q[6], lk[i][0]);
      sync_run <= 1'b0;
      repeat (40) @(posedge clock_i);
    end
    bus(1'b1, REG_CTRL, 32'h3, 4'h1);
    $display("lock done");
    pwr(3'h4);
    sync_run <= 1'b1;
    cnt(3, 160);
    // One gate sequence spans three 8-clock sync periods, so high side fires every third
    chk(r >= 6 && r <= 7, 1'b1);
    sync_run <= 1'b0;
    repeat (20) @(posedge clock_i);
    cnt(3, 80);
    chk(r, 0);
    enable_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
    chk(soft_start_pull_low_o, 1'b1);
    enable_i <= 1'b1;
    sync_run <= 1'b1;
    wt(2, 100);
    chk(soft_start_pull_low_o, 1'b0);
    sync_run <= 1'b0;
    $display("secondary done");
    conclude();
  end
endmodule : bkoc_ctrl_test
`default_nettype wire
